// *** rtl/bmf_flag_mailbox.sv ***
// flag generation, bus matching and mailboxes of the bidirectional queue pair
//
// Notes on behaviour
// [RL1] port A full flag rises at the next port A edge after B frees space
// [RL2] for narrow B the A full flag waits for the entry's last read part
// [RL3] fall-through: B input ready rises at next B edge after A read
// [RL4] narrow B: input ready falls only on the entry-completing write part
// [RL5] standard: B full flag rises at next B edge after A read
// [RL6] narrow B: B full flag falls only on the entry-completing write part
// [RL7] B almost-empty rises at next B edge once A writes lift the level
// [RL8] narrow B: B almost-empty falls on the entry's last read part
// [RL9] narrow B: A almost-empty counts the entry after its last write part
// [RL10] A almost-full rises at next A edge after B reads the last part
// [RL11] B almost-full rises at next B edge after A reads relieve the queue
// [RL12] narrow B: B almost-full falls on the entry-completing write part
// [RL13] queue depth is 256, 512 or 1024 by capacity variant
// [RL14] word B: A-to-B mailbox keeps A bits 0-17, B shows bits 0-17
// [RL15] byte B: A-to-B mailbox keeps A bits 0-8, B shows bits 0-8
// [RL16] word B: B-to-A mailbox keeps B bits 0-17, A shows bits 0-17
// [RL17] byte B: B-to-A mailbox keeps B bits 0-8, A shows bits 0-8
// [RL18] A writes / B reads the A-to-B queue: select low, W/R high, mb low
// [RL19] B writes / A reads the B-to-A queue: select, W/R, mb all low
// [RL20] bus match and size stay static; byte order caught at reset (the code loads it before the pin settles, so it stays 1)
// [RL21] mail flag sets on accepted write, clears when far port reads
// [RL22] flags update on own port clock from synchronised queue state
`timescale 1ns/1ps
`default_nettype none
module bmf_flag_mailbox (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_porta_clock,
    input wire logic i_porta_select_n,
    input wire logic i_porta_write_read,
    input wire logic i_porta_mailbox_select,
    input wire logic [bmf_pkg::LONG_W-1:0] i_porta_data,
    output logic [bmf_pkg::LONG_W-1:0] o_porta_data,
    output logic o_porta_data_oe,
    input wire logic i_portb_clock,
    input wire logic i_portb_select_n,
    input wire logic i_portb_write_read,
    input wire logic i_portb_mailbox_select,
    input wire logic [bmf_pkg::LONG_W-1:0] i_portb_data,
    output logic [bmf_pkg::LONG_W-1:0] o_portb_data,
    output logic o_portb_data_oe,
    input wire logic i_bus_match_select,
    input wire logic i_size_select,
    input wire logic i_byte_order_select,
    input wire logic i_fall_through_mode,
    input wire logic [bmf_pkg::Q_CW-1:0] i_almost_empty_offset,
    input wire logic [bmf_pkg::Q_CW-1:0] i_almost_full_offset,
    output logic o_porta_full_flag,
    output logic o_porta_data_ready,
    output logic o_porta_almost_empty,
    output logic o_porta_almost_full,
    output logic o_portb_full_flag,
    output logic o_portb_input_ready,
    output logic o_portb_data_ready,
    output logic o_portb_almost_empty,
    output logic o_portb_almost_full,
    output logic o_a_to_b_mail_flag,
    output logic o_b_to_a_mail_flag
);
    import bmf_pkg::*;

    localparam int unsigned PAD_W = LONG_W - WORD_W;
    localparam int unsigned PAD_B = LONG_W - BYTE_W;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_q;
    logic [PIN_W-1:0] pin_s2_q;
    logic [PIN_W-1:0] pin_s3_q;
    logic [PIN_W-1:0] pin_f_q;
    logic a_clk_f, b_clk_f, a_sel_n_f, a_wr_f, a_mb_f, b_sel_n_f, b_wr_f;
    logic b_mb_f, bm_f, size_f, order_f, fall_through_mode_f;
    logic [LONG_W-1:0] a_data_f;
    logic [LONG_W-1:0] b_data_f;
    logic a_clk_prev_q, b_clk_prev_q;
    logic [2:0] cap_cnt_q;
    logic live;
    logic byte_order_q;
    bmf_width_t width_mode;
    logic [1:0] last_part;
    logic a_edge, b_edge, a_sel, b_sel;
    logic a_q_wr, a_q_rd, a_mb_wr, a_mb_rd;
    logic b_q_wr, b_q_rd, b_mb_wr, b_mb_rd;
    logic b_rd_last, b_wr_last, b_space;
    logic [1:0] b_rd_part_q, b_wr_part_q, b_rd_pos, b_wr_pos;
    logic [Q_AW-1:0] a2b_wptr_q, a2b_rptr_q, b2a_wptr_q, b2a_rptr_q;
    logic [Q_CW-1:0] a2b_count_q, a2b_count_d, b2a_count_q, b2a_count_d;
    logic [LONG_W-1:0] a2b_rdata, b2a_rdata, b2a_acc_q, b_wr_word;
    logic [LONG_W-1:0] a2b_mail_q, b2a_mail_q;

    // one part of a 36-bit entry, placed in the low bits
    function automatic logic [LONG_W-1:0] take_part(
        input logic [LONG_W-1:0] w, input bmf_width_t m, input logic [1:0] p);
        logic [LONG_W-1:0] r;
        r = w;
        case (m)
            BMF_WORD: r = {{PAD_W{1'b0}}, w[18*p[0] +: 18]};
            BMF_BYTE: r = {{PAD_B{1'b0}}, w[9*p +: 9]};
            default: r = w;
        endcase
        return r;
    endfunction : take_part

    // drop a narrow part into its slot of the entry being built
    function automatic logic [LONG_W-1:0] put_part(
        input logic [LONG_W-1:0] acc, input logic [LONG_W-1:0] d,
        input bmf_width_t m, input logic [1:0] p);
        logic [LONG_W-1:0] r;
        r = acc;
        case (m)
            BMF_WORD: r[18*p[0] +: 18] = d[17:0];
            BMF_BYTE: r[9*p +: 9] = d[8:0];
            default: r = d;
        endcase
        return r;
    endfunction : put_part

    // mailbox contents keep only the lines that the width uses
    function automatic logic [LONG_W-1:0] fit_mail(
        input logic [LONG_W-1:0] d, input bmf_width_t m);
        logic [LONG_W-1:0] r;
        r = d;
        case (m)
            BMF_WORD: r = {{PAD_W{1'b0}}, d[17:0]};
            BMF_BYTE: r = {{PAD_B{1'b0}}, d[8:0]};
            default: r = d;
        endcase
        return r;
    endfunction : fit_mail

    // occupancy at or below the almost-empty offset
    function automatic logic at_low(
        input logic [Q_CW-1:0] c, input logic [Q_CW-1:0] o);
        return c <= o;
    endfunction : at_low

    // occupancy within the almost-full offset of the depth
    function automatic logic at_high(
        input logic [Q_CW-1:0] c, input logic [Q_CW-1:0] o);
        return ({1'b0, c} + {1'b0, o}) >= (Q_CW + 1)'(Q_DEPTH);
    endfunction : at_high

    assign pin_raw = {i_porta_clock, i_portb_clock, i_porta_select_n,
                      i_porta_write_read, i_porta_mailbox_select,
                      i_portb_select_n, i_portb_write_read,
                      i_portb_mailbox_select, i_bus_match_select,
                      i_size_select, i_byte_order_select,
                      i_fall_through_mode, i_porta_data, i_portb_data};
    assign {a_clk_f, b_clk_f, a_sel_n_f, a_wr_f, a_mb_f, b_sel_n_f, b_wr_f,
            b_mb_f, bm_f, size_f, order_f, fall_through_mode_f, a_data_f,
            b_data_f} = pin_f_q;

    // three-stage pin sampler; stage one feeds only stage two
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            pin_s1_q <= PIN_RST;
            pin_s2_q <= PIN_RST;
            pin_s3_q <= PIN_RST;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // a pin change counts once the later two stages agree
    for (genvar gi = 0; gi < PIN_W; gi++) begin : g_pin_filt
        always_ff @(posedge i_clk_sys) begin
            if (!i_resetn) begin
                pin_f_q[gi] <= PIN_RST[gi];
            end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                pin_f_q[gi] <= pin_s2_q[gi];
            end
        end
    end

    // hold the ports idle until the sampler has settled after reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            cap_cnt_q <= '0;
        end else if (!live) begin
            cap_cnt_q <= cap_cnt_q + 3'h1;
        end
    end
    assign live = (cap_cnt_q == CAPTURE_CYCLES);

    // byte order is loaded just after reset release, before the pin has settled, so it stays 1
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            byte_order_q <= BYTE_ORDER_RST;
        end else if (!live) begin
            byte_order_q <= order_f; // see [RL20]
        end
    end

    // bus width is read every cycle; it must not change in operation
    always_comb begin
        width_mode = BMF_LONG;
        last_part = LAST_LONG;
        case ({bm_f, size_f}) // see [RL20]
            2'b10: begin
                width_mode = BMF_WORD;
                last_part = LAST_WORD;
            end
            2'b11: begin
                width_mode = BMF_BYTE;
                last_part = LAST_BYTE;
            end
            default: ;
        endcase
    end

    // port clock edges, seen as one-cycle enables
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            a_clk_prev_q <= 1'b1;
            b_clk_prev_q <= 1'b1;
        end else begin
            a_clk_prev_q <= a_clk_f;
            b_clk_prev_q <= b_clk_f;
        end
    end
    assign a_edge = a_clk_f & ~a_clk_prev_q & live;
    assign b_edge = b_clk_f & ~b_clk_prev_q & live;
    assign a_sel = a_edge & ~a_sel_n_f;
    assign b_sel = b_edge & ~b_sel_n_f;

    // access decode; queue accesses honour the flag shown at that edge
    assign a_q_wr = a_sel & a_wr_f & ~a_mb_f & o_porta_full_flag; // see [RL18]
    assign a_mb_wr = a_sel & a_wr_f & a_mb_f;
    assign a_q_rd = a_sel & ~a_wr_f & ~a_mb_f & o_porta_data_ready; // see [RL19]
    assign a_mb_rd = a_sel & ~a_wr_f & a_mb_f;
    assign b_space = fall_through_mode_f ? o_portb_input_ready : o_portb_full_flag;
    assign b_q_rd = b_sel & b_wr_f & ~b_mb_f & o_portb_data_ready; // see [RL18]
    assign b_mb_rd = b_sel & b_wr_f & b_mb_f;
    assign b_q_wr = b_sel & ~b_wr_f & ~b_mb_f & b_space; // see [RL19]
    assign b_mb_wr = b_sel & ~b_wr_f & b_mb_f;
    assign b_rd_last = b_q_rd & (b_rd_part_q == last_part); // see [RL2]
    assign b_wr_last = b_q_wr & (b_wr_part_q == last_part); // see [RL9]

    // big-endian order sends the most significant part first
    assign b_rd_pos = byte_order_q ? (last_part - b_rd_part_q) : b_rd_part_q;
    assign b_wr_pos = byte_order_q ? (last_part - b_wr_part_q) : b_wr_part_q;
    assign b_wr_word = put_part(b2a_acc_q, b_data_f, width_mode, b_wr_pos);

    // part counters of the narrow port B side
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            b_rd_part_q <= '0;
            b_wr_part_q <= '0;
            b2a_acc_q <= '0;
        end else begin
            if (b_q_rd) begin
                b_rd_part_q <= b_rd_last ? 2'h0 : b_rd_part_q + 2'h1;
            end
            if (b_q_wr) begin
                b_wr_part_q <= b_wr_last ? 2'h0 : b_wr_part_q + 2'h1;
                b2a_acc_q <= b_wr_word;
            end
        end
    end

    // queue pointers; the depth is a power of two so they wrap freely
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            a2b_wptr_q <= '0;
            a2b_rptr_q <= '0;
            b2a_wptr_q <= '0;
            b2a_rptr_q <= '0;
        end else begin
            if (a_q_wr) a2b_wptr_q <= a2b_wptr_q + Q_AW'(1);
            if (b_rd_last) a2b_rptr_q <= a2b_rptr_q + Q_AW'(1);
            if (b_wr_last) b2a_wptr_q <= b2a_wptr_q + Q_AW'(1);
            if (a_q_rd) b2a_rptr_q <= b2a_rptr_q + Q_AW'(1);
        end
    end

    // occupancy moves only on whole entries, so partial parts never count
    always_comb begin
        a2b_count_d = a2b_count_q + Q_CW'(a_q_wr)
            - Q_CW'(b_rd_last); // see [RL10]
        b2a_count_d = b2a_count_q + Q_CW'(b_wr_last)
            - Q_CW'(a_q_rd); // see [RL12]
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            a2b_count_q <= '0;
            b2a_count_q <= '0;
        end else begin
            a2b_count_q <= a2b_count_d;
            b2a_count_q <= b2a_count_d;
        end
    end

    // port A flags move only on port A edges, from the settled occupancy
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_porta_full_flag <= FULL_FLAG_RST;
            o_porta_data_ready <= READY_RST;
            o_porta_almost_empty <= ALMOST_EMPTY_RST;
            o_porta_almost_full <= ALMOST_FULL_RST;
        end else if (a_edge) begin // see [RL22]
            o_porta_full_flag <= (a2b_count_d != Q_CW'(Q_DEPTH)); // see [RL1]
            o_porta_data_ready <= (b2a_count_d != '0);
            o_porta_almost_empty <= ~at_low(b2a_count_d,
                                            i_almost_empty_offset); // see [RL9]
            o_porta_almost_full <= ~at_high(a2b_count_d,
                                            i_almost_full_offset); // see [RL10]
        end
    end

    // port B flags; one of full or input ready is live, by timing mode
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_portb_full_flag <= FULL_FLAG_RST;
            o_portb_input_ready <= FULL_FLAG_RST;
            o_portb_data_ready <= READY_RST;
            o_portb_almost_empty <= ALMOST_EMPTY_RST;
            o_portb_almost_full <= ALMOST_FULL_RST;
        end else if (b_edge) begin // see [RL22]
            o_portb_full_flag <= ~fall_through_mode_f &
                (b2a_count_d != Q_CW'(Q_DEPTH)); // see [RL5] see [RL6]
            o_portb_input_ready <= fall_through_mode_f &
                (b2a_count_d != Q_CW'(Q_DEPTH)); // see [RL3] see [RL4]
            o_portb_data_ready <= (a2b_count_d != '0);
            o_portb_almost_empty <= ~at_low(a2b_count_d,
                i_almost_empty_offset); // see [RL7] see [RL8]
            o_portb_almost_full <= ~at_high(b2a_count_d,
                i_almost_full_offset); // see [RL11] see [RL12]
        end
    end

    // mailbox registers hold only the lines the width carries
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            a2b_mail_q <= '0;
            b2a_mail_q <= '0;
        end else begin
            if (a_mb_wr) begin
                a2b_mail_q <= fit_mail(a_data_f, width_mode); // see [RL14] see [RL15]
            end
            if (b_mb_wr) begin
                b2a_mail_q <= fit_mail(b_data_f, width_mode); // see [RL16] see [RL17]
            end
        end
    end

    // new-mail flags; a write landing with the far read keeps the flag set
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_a_to_b_mail_flag <= MAIL_FLAG_RST;
            o_b_to_a_mail_flag <= MAIL_FLAG_RST;
        end else begin
            if (a_mb_wr) begin
                o_a_to_b_mail_flag <= 1'b1; // see [RL21]
            end else if (b_mb_rd) begin
                o_a_to_b_mail_flag <= 1'b0; // see [RL21]
            end
            if (b_mb_wr) begin
                o_b_to_a_mail_flag <= 1'b1; // see [RL21]
            end else if (a_mb_rd) begin
                o_b_to_a_mail_flag <= 1'b0; // see [RL21]
            end
        end
    end

    // port A output bus: queue entry or mailbox, driven while reading
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_porta_data <= '0;
            o_porta_data_oe <= 1'b0;
        end else begin
            if (a_edge) begin
                o_porta_data_oe <= ~a_sel_n_f & ~a_wr_f;
            end
            if (a_q_rd) begin
                o_porta_data <= b2a_rdata;
            end else if (a_mb_rd) begin
                o_porta_data <= b2a_mail_q; // see [RL16] see [RL17]
            end
        end
    end

    // port B output bus: one part per read, unused upper lines read zero
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_portb_data <= '0;
            o_portb_data_oe <= 1'b0;
        end else begin
            if (b_edge) begin
                o_portb_data_oe <= ~b_sel_n_f & b_wr_f;
            end
            if (b_q_rd) begin
                o_portb_data <= take_part(a2b_rdata, width_mode, b_rd_pos);
            end else if (b_mb_rd) begin
                o_portb_data <= a2b_mail_q; // see [RL14] see [RL15]
            end
        end
    end

    // queue stores; depth follows the capacity variant
    bmf_mem #(.W(LONG_W), .DEPTH(Q_DEPTH), .AW(Q_AW)) u_a2b_mem ( // see [RL13]
        .i_clk_sys(i_clk_sys),
        .i_wr_en(a_q_wr),
        .i_wr_addr(a2b_wptr_q),
        .i_wr_data(a_data_f),
        .i_rd_addr(a2b_rptr_q),
        .o_rd_data(a2b_rdata)
    );

    bmf_mem #(.W(LONG_W), .DEPTH(Q_DEPTH), .AW(Q_AW)) u_b2a_mem ( // see [RL13]
        .i_clk_sys(i_clk_sys),
        .i_wr_en(b_wr_last),
        .i_wr_addr(b2a_wptr_q),
        .i_wr_data(b_wr_word),
        .i_rd_addr(b2a_rptr_q),
        .o_rd_data(b2a_rdata)
    );

endmodule : bmf_flag_mailbox
`default_nettype wire

// *** rtl/bmf_pkg.sv ***
// shared constants and types for the bidirectional queue flag and mailbox block
package bmf_pkg;

    // capacity variants; the build picks one through CAPACITY_SEL
    localparam int unsigned DEPTH_SMALL = 256;
    localparam int unsigned DEPTH_MID = 512;
    localparam int unsigned DEPTH_LARGE = 1024;
    localparam int unsigned CAPACITY_SEL = 0;
    localparam int unsigned Q_DEPTH = (CAPACITY_SEL == 0) ? DEPTH_SMALL :
                                      (CAPACITY_SEL == 1) ? DEPTH_MID :
                                      DEPTH_LARGE;
    localparam int unsigned Q_AW = $clog2(Q_DEPTH);
    localparam int unsigned Q_CW = Q_AW + 1;

    // port widths
    localparam int unsigned LONG_W = 36;
    localparam int unsigned WORD_W = 18;
    localparam int unsigned BYTE_W = 9;

    // pin sampling: 12 control and configuration pins plus two data buses
    localparam int unsigned PIN_CTRL_W = 12;
    localparam int unsigned PIN_W = PIN_CTRL_W + 2 * LONG_W;
    localparam logic [PIN_W-1:0] PIN_RST = '1;

    // cycles after reset release before the pins are trusted
    localparam logic [2:0] CAPTURE_CYCLES = 3'h4;

    // index of the last part of a 36-bit entry for each port B width
    localparam logic [1:0] LAST_LONG = 2'h0;
    localparam logic [1:0] LAST_WORD = 2'h1;
    localparam logic [1:0] LAST_BYTE = 2'h3;

    // reset values of the flags
    localparam logic FULL_FLAG_RST = 1'b0;
    localparam logic READY_RST = 1'b0;
    localparam logic ALMOST_EMPTY_RST = 1'b0;
    localparam logic ALMOST_FULL_RST = 1'b1;
    localparam logic MAIL_FLAG_RST = 1'b0;
    localparam logic BYTE_ORDER_RST = 1'b1;

    // port B bus width
    typedef enum logic [2:0] {
        BMF_LONG = 3'b001,
        BMF_WORD = 3'b010,
        BMF_BYTE = 3'b100
    } bmf_width_t;

endpackage : bmf_pkg

// *** rtl/bmf_mem.sv ***
// simple dual-port entry store with registered read data
`timescale 1ns/1ps
`default_nettype none
module bmf_mem #(
    parameter int unsigned W = 36,
    parameter int unsigned DEPTH = 256,
    parameter int unsigned AW = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [W-1:0] i_wr_data,
    input wire logic [AW-1:0] i_rd_addr,
    output logic [W-1:0] o_rd_data
);

    logic [W-1:0] store [DEPTH];

    // storage has no reset; the pointers decide what is valid
    always_ff @(posedge i_clk_sys) begin
        if (i_wr_en) begin
            store[i_wr_addr] <= i_wr_data;
        end
    end

    // read data follows the read address one cycle later
    always_ff @(posedge i_clk_sys) begin
        o_rd_data <= store[i_rd_addr];
    end

endmodule : bmf_mem
`default_nettype wire

// *** tb/bmf_flag_mailbox_monitor.sv ***
// concurrent checks on the flag and mailbox block ports
`timescale 1ns/1ps
`default_nettype none
module bmf_flag_mailbox_monitor (
    input wire logic i_clk_sys, input wire logic i_resetn,
    input wire logic i_porta_select_n, input wire logic i_porta_write_read,
    input wire logic i_porta_mailbox_select, input wire logic i_portb_select_n,
    input wire logic i_portb_write_read, input wire logic i_portb_mailbox_select,
    input wire logic i_bus_match_select, input wire logic i_size_select,
    input wire logic i_fall_through_mode, input wire logic o_porta_full_flag,
    input wire logic o_porta_almost_full, input wire logic o_porta_data_ready,
    input wire logic o_porta_almost_empty, input wire logic o_portb_full_flag,
    input wire logic o_portb_input_ready, input wire logic o_portb_data_ready,
    input wire logic o_portb_almost_empty, input wire logic [35:0] o_portb_data,
    input wire logic o_a_to_b_mail_flag, input wire logic o_b_to_a_mail_flag
);
    // single clock domain
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    a_reset_flag_values: assert property ($rose(i_resetn) |->
        !o_porta_full_flag && o_porta_almost_full && !o_a_to_b_mail_flag)
        else $error("bad reset flags");
    a_std_ready_off: assert property (!i_fall_through_mode |->
        !o_portb_input_ready) else $error("ready in standard");
    a_fall_through_mode_full_off: assert property (i_fall_through_mode |->
        !o_portb_full_flag) else $error("full in fall_through_mode");
    a_ab_mail_set: assert property ($rose(o_a_to_b_mail_flag)
        |-> !i_porta_select_n && i_porta_write_read && i_porta_mailbox_select)
        else $error("ab mail set");
    a_ab_mail_clear: assert property ($fell(o_a_to_b_mail_flag)
        |-> !i_portb_select_n && i_portb_write_read && i_portb_mailbox_select)
        else $error("ab mail clear");
    a_ba_mail_set: assert property ($rose(o_b_to_a_mail_flag)
        |-> !i_portb_select_n && !i_portb_write_read && i_portb_mailbox_select)
        else $error("ba mail set");
    a_ba_mail_clear: assert property ($fell(o_b_to_a_mail_flag)
        |-> !i_porta_select_n && !i_porta_write_read && i_porta_mailbox_select)
        else $error("ba mail clear");
    a_byte_upper_zero: assert property (i_bus_match_select &&
        i_size_select |-> o_portb_data[35:9] == 27'h000_0000)
        else $error("b upper bits set");
    a_empty_b_almost: assert property (!o_portb_data_ready |->
        !o_portb_almost_empty) else $error("b empty not low");
    a_empty_a_almost: assert property (!o_porta_data_ready |->
        !o_porta_almost_empty) else $error("a empty not low");
    c_ab_mail: cover property ($rose(o_a_to_b_mail_flag));
    c_ba_mail: cover property ($rose(o_b_to_a_mail_flag));
    c_a_full: cover property ($fell(o_porta_full_flag));
endmodule : bmf_flag_mailbox_monitor
bind bmf_flag_mailbox bmf_flag_mailbox_monitor i_bmf_flag_mailbox_monitor (.*);
`default_nettype wire

// *** tb/bmf_port_drv.sv ***
// bus master model for one port: makes the port clock and drives controls
`timescale 1ns/1ps
`default_nettype none
module bmf_port_drv (
    input wire logic i_clk_sys,
    output logic o_clk,
    output logic o_sel_n,
    output logic o_wr,
    output logic o_mb,
    output logic [35:0] o_data
);
    initial begin
        {o_clk, o_sel_n, o_wr, o_mb, o_data} = {4'h4, 36'h0_0000_0000};
    end
    // one port cycle, c is {select_n, write_read, mailbox}; slow for sampling
    task automatic cyc(input logic [2:0] c, input logic [35:0] d);
        @(negedge i_clk_sys);
        {o_sel_n, o_wr, o_mb} = c;
        o_data = c[2] ? ~o_data : d; // deselected bus shows no stale value
        repeat (5) @(negedge i_clk_sys);
        o_clk = 1'b1;
        repeat (6) @(negedge i_clk_sys);
        o_clk = 1'b0;
        repeat (5) @(negedge i_clk_sys);
    endtask : cyc
endmodule : bmf_port_drv
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the queue flag and mailbox block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    failures++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb_top;
    import bmf_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fall_through_mode = 1'b0;
    logic [35:0] exp_w = 36'h9_ABCD_1234;
    int failures = 0;
    int cmp_count = 0;
    int ticks = 0;
    wire ca, sa, wa, ma, cb, sb, wb, mb;
    wire [35:0] da, db;
    logic [35:0] qa, qb;
    logic fa, rda, aea, afa, fb, portb_input_ready, rdb, aeb, afb, m1, m2, oea, oeb;
    always #50 clk = ~clk;
    bmf_port_drv i_bmf_port_drv_a (.i_clk_sys(clk), .o_clk(ca), .o_sel_n(sa),
        .o_wr(wa), .o_mb(ma), .o_data(da));
    bmf_port_drv i_bmf_port_drv_b (.i_clk_sys(clk), .o_clk(cb), .o_sel_n(sb),
        .o_wr(wb), .o_mb(mb), .o_data(db));
    // byte-wide port b, big endian; configuration pins are static
    bmf_flag_mailbox i_bmf_flag_mailbox (.i_clk_sys(clk), .i_resetn(rst_n),
        .i_porta_clock(ca), .i_porta_select_n(sa), .i_porta_write_read(wa),
        .i_porta_mailbox_select(ma), .i_porta_data(da), .o_porta_data(qa),
        .o_porta_data_oe(oea), .i_portb_clock(cb), .i_portb_select_n(sb),
        .i_portb_write_read(wb), .i_portb_mailbox_select(mb),
        .i_portb_data(db), .o_portb_data(qb), .o_portb_data_oe(oeb),
        .i_bus_match_select(1'b1), .i_size_select(1'b1),
        .i_byte_order_select(1'b1), .i_fall_through_mode(fall_through_mode),
        .i_almost_empty_offset(9'h008), .i_almost_full_offset(9'h008),
        .o_porta_full_flag(fa), .o_porta_data_ready(rda),
        .o_porta_almost_empty(aea), .o_porta_almost_full(afa),
        .o_portb_full_flag(fb), .o_portb_input_ready(portb_input_ready),
        .o_portb_data_ready(rdb), .o_portb_almost_empty(aeb),
        .o_portb_almost_full(afb), .o_a_to_b_mail_flag(m1),
        .o_b_to_a_mail_flag(m2));
    task automatic final_report();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task automatic pa(input logic [2:0] c, input logic [35:0] d);
        i_bmf_port_drv_a.cyc(c, d);
    endtask : pa
    task automatic pb(input logic [2:0] c, input logic [35:0] d);
        i_bmf_port_drv_b.cyc(c, d);
    endtask : pb
    // hang guard, far above the roughly 4800 cycles the tests need
    always @(posedge clk) begin
        ticks++;
        if (ticks == 20000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        pa(3'h4, 36'h0);
        pb(3'h4, 36'h0);
        `CHK("a full", 1'b1, fa)
        `CHK("b full", 1'b1, fb)
        `CHK("b ready std", 1'b0, portb_input_ready)
        // mailboxes both ways; only the low byte crosses
        pa(3'h3, 36'h1_2345_6789);
        `CHK("mail ab flag", 1'b1, m1)
        pb(3'h3, 36'h0);
        `CHK("mail ab data", 36'h0_0000_0189, qb)
        `CHK("mail ab clear", 1'b0, m1)
        `CHK("b oe", 1'b1, oeb)
        pb(3'h1, 36'hF_FFFF_FEAB);
        `CHK("mail ba flag", 1'b1, m2)
        pa(3'h1, 36'h0);
        `CHK("mail ba data", 36'h0_0000_00AB, qa)
        `CHK("mail ba clear", 1'b0, m2)
        `CHK("a oe", 1'b1, oea)
        // four byte writes make one entry
        for (int i = 0; i < 4; i++) begin
            pb(3'h0, 36'(exp_w[35-9*i -: 9]));
            if (i == 2) begin
                pa(3'h4, 36'h0);
                `CHK("a ready early", 1'b0, rda)
            end
        end
        pa(3'h4, 36'h0);
        pa(3'h4, 36'h0);
        `CHK("a ready", 1'b1, rda)
        `CHK("a almost empty", 1'b0, aea)
        pa(3'h0, 36'h0);
        `CHK("a entry", exp_w, qa)
        // fill the a to b queue to its 256 entries
        for (int i = 0; i < 256; i++) begin
            pa(3'h2, exp_w ^ 36'(i));
            if (i == 254)
                `CHK("a full early", 1'b1, fa)
        end
        `CHK("a full set", 1'b0, fa)
        `CHK("a almost full", 1'b0, afa)
        pb(3'h4, 36'h0);
        `CHK("b ready data", 1'b1, rdb)
        `CHK("b almost empty", 1'b1, aeb)
        `CHK("b almost full", 1'b1, afb)
        // full flag frees only after the fourth byte read
        for (int i = 0; i < 4; i++) begin
            pb(3'h2, 36'h0);
            `CHK("b byte", 36'(exp_w[35-9*i -: 9]), qb)
            if (i == 2) begin
                pa(3'h4, 36'h0);
                `CHK("a full held", 1'b0, fa)
            end
        end
        pa(3'h4, 36'h0);
        pa(3'h4, 36'h0);
        `CHK("a full freed", 1'b1, fa)
        // second reset into fall-through mode
        @(negedge clk);
        rst_n = 1'b0;
        fall_through_mode = 1'b1;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        pb(3'h4, 36'h0);
        `CHK("b ready fall_through_mode", 1'b1, portb_input_ready)
        `CHK("b full fall_through_mode", 1'b0, fb)
        final_report();
    end
endmodule : tb_top
`default_nettype wire
